// [logic/ccu_pkg.sv]
// package: constants and carriers for the checksum calculation unit
`default_nettype none
package ccu_pkg;
	localparam logic [15:0] CCU_POLY16 = 16'h8005;
	localparam logic [15:0] CCU_POLY_CCITT = 16'h1021;
	localparam logic [31:0] CCU_POLY32 = 32'h04C11DB7;
	localparam logic [31:0] CCU_SEED_RST = 32'h00000000;
	localparam logic [1:0] CCU_STEPS_BYTE = 2'h0;
	localparam logic [1:0] CCU_STEPS_HALF = 2'h1;
	localparam logic [1:0] CCU_STEPS_WORD = 2'h3;

	typedef enum logic [1:0] {
		CCU_MODE_CRC16 = 2'h0,
		CCU_MODE_CCITT = 2'h1,
		CCU_MODE_CRC32 = 2'h2
	} ccu_mode_e;

	typedef enum logic [1:0] {
		CCU_SIZE_BYTE = 2'h0,
		CCU_SIZE_HALF = 2'h1,
		CCU_SIZE_WORD = 2'h2
	} ccu_size_e;

	typedef enum logic [1:0] {
		CCU_ST_IDLE = 2'h0,
		CCU_ST_BUSY = 2'h1
	} ccu_state_e;

	typedef struct packed {
		ccu_mode_e mode;
		logic dat_cmpl;
		logic dat_byte_rev;
		logic dat_bit_rev;
		logic sum_cmpl;
		logic sum_byte_rev;
		logic sum_bit_rev;
	} ccu_cfg_s;
endpackage
`default_nettype wire

// [logic/ccu_byte_step.sv]
// one byte folded into a 32-bit remainder, msb first, selectable polynomial
`default_nettype none
module ccu_byte_step (
	input wire ccu_pkg::ccu_mode_e mode, // polynomial select
	input wire logic [31:0] crc_in, // running remainder
	input wire logic [7:0] data_in, // byte to fold
	output logic [31:0] crc_out // updated remainder
);
	import ccu_pkg::*;

	always_comb begin
		logic [31:0] c;
		logic fb;
		c = crc_in;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (mode == CCU_MODE_CRC32) begin
				fb = c[31] ^ data_in[i];
				c = {c[30:0], 1'b0} ^ (fb ? CCU_POLY32 : 32'h00000000);
			end else begin
				fb = c[15] ^ data_in[i];
				c = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, fb ? ((mode == CCU_MODE_CCITT) ?
					CCU_POLY_CCITT : CCU_POLY16) : 16'h0000};
			end
		end
		crc_out = c;
	end
endmodule
`default_nettype wire

// [logic/ccu_top.sv]
// checksum calculation unit: data input, seed, options and result
// Functional notes
// - 16-bit mode with polynomial 0x8005.
// - 16-bit CCITT mode with polynomial 0x1021.
// - 32-bit mode with polynomial 0x04C11DB7.
// - complement, byte reverse and bit reverse selectable on data and on result.
// - data writes may be byte, half-word or word, folded by size.
// - software programs the starting seed.
// - a byte takes one clock, a word four clocks.
// - data input accepts dma writes for whole memory blocks.
// - result is 16 bits in 16-bit modes, 32 bits in 32-bit mode.
`default_nettype none
module ccu_top (
	input wire logic clock, // 200 MHz bus clock
	input wire logic sys_rst, // async reset, active high
	input wire ccu_pkg::ccu_cfg_s cfg, // polynomial and option selects
	input wire logic [31:0] seed, // seed value
	input wire logic seed_wr, // seed write strobe
	input wire logic [31:0] data, // data word, narrow data in low bits
	input wire ccu_pkg::ccu_size_e data_size, // size of this write
	input wire logic data_wr, // data write strobe (cpu or dma)
	output logic data_ready, // high when a new data write is taken
	output logic busy, // fold in progress
	output logic [31:0] result // checksum after output options
);
	import ccu_pkg::*;

	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] ccu_bitrev32(input logic [31:0] v);
		logic [31:0] r;
		r = 32'h00000000;
		for (int i = 0; i < 32; i++) begin
			r[i] = v[31 - i];
		end
		return r;
	endfunction

	function automatic logic [31:0] ccu_byterev32(input logic [31:0] v);
		return {v[7:0], v[15:8], v[23:16], v[31:24]};
	endfunction

	// reverse within the active width of the data write
	function automatic logic [31:0] ccu_dat_fmt(input logic [31:0] v, input ccu_size_e sz, input ccu_cfg_s c);
		logic [31:0] r;
		r = v;
		if (c.dat_cmpl) begin
			r = ~r;
		end
		if (c.dat_byte_rev) begin
			r = ccu_byterev32(r);
			if (sz == CCU_SIZE_HALF) begin
				r = {16'h0000, r[31:16]};
			end else if (sz == CCU_SIZE_BYTE) begin
				r = {24'h000000, r[31:24]};
			end
		end
		if (c.dat_bit_rev) begin
			r = {ccu_byterev32(ccu_bitrev32(r))}; // bits mirrored inside each byte
		end
		return r;
	endfunction

	// ************************************************************
	// state
	// ************************************************************
	ccu_state_e state_reg, state_next;
	logic [31:0] crc_reg, crc_next;
	logic [31:0] buf_reg, buf_next;
	logic [1:0] left_reg, left_next;
	ccu_mode_e mode_reg, mode_next;
	logic [31:0] result_reg, result_next;
	logic ready_reg, ready_next;
	// busy and ready are both flops so the outputs carry no decode logic
	logic busy_reg, busy_next;
	logic [31:0] step_out;
	logic [31:0] fmt_word;
	logic [31:0] sum_view;
	// full mirror of the next remainder, read by the 16-bit view
	logic [31:0] sum_rev;

	// the byte stepper sees buffered data msb byte first so all sizes share one order
	ccu_byte_step u_step (
		.mode(mode_reg),
		.crc_in(crc_reg),
		.data_in(buf_reg[31:24]),
		.crc_out(step_out)
	);

	always_comb begin
		state_next = state_reg;
		crc_next = crc_reg;
		buf_next = buf_reg;
		left_next = left_reg;
		// the polynomial is frozen while a fold runs so a late mode change cannot split a word
		mode_next = mode_reg;
		fmt_word = ccu_dat_fmt(data, data_size, cfg);
		ready_next = 1'b0;
		case (state_reg)
			CCU_ST_IDLE: begin
				mode_next = cfg.mode;
				ready_next = ~data_wr & ~seed_wr;
				// a seed write wins over a data write in the same cycle
				if (seed_wr) begin
					crc_next = seed;
				end else if (data_wr) begin
					state_next = CCU_ST_BUSY;
					case (data_size)
						CCU_SIZE_BYTE: begin
							buf_next = {fmt_word[7:0], 24'h000000};
							left_next = CCU_STEPS_BYTE;
						end
						CCU_SIZE_HALF: begin
							buf_next = {fmt_word[15:0], 16'h0000};
							left_next = CCU_STEPS_HALF;
						end
						default: begin
							buf_next = fmt_word;
							left_next = CCU_STEPS_WORD;
						end
					endcase
				end
			end
			CCU_ST_BUSY: begin
				crc_next = step_out;
				buf_next = {buf_reg[23:0], 8'h00};
				if (left_reg == 2'h0) begin
					state_next = CCU_ST_IDLE;
					ready_next = 1'b1;
				end else begin
					left_next = left_reg - 2'h1;
				end
			end
			default: begin
				state_next = CCU_ST_IDLE;
			end
		endcase
		// busy is registered so the pin never glitches with the state decode
		busy_next = (state_next == CCU_ST_BUSY);
	end

	// ************************************************************
	// output options on the remainder
	// ************************************************************
	// the view follows the mode that the remainder will be stepped with, so a seed
	// written together with a mode change is shown in the new width at once
	always_comb begin
		sum_view = crc_next;
		// mirroring all 32 bits puts the low half, reversed, into the upper half
		sum_rev = ccu_bitrev32(crc_next);
		if (mode_next != CCU_MODE_CRC32) begin
			sum_view = {16'h0000, sum_view[15:0]};
			if (cfg.sum_bit_rev) begin
				sum_view = {16'h0000, sum_rev[31:16]};
			end
			if (cfg.sum_byte_rev) begin
				sum_view = {16'h0000, sum_view[7:0], sum_view[15:8]};
			end
			if (cfg.sum_cmpl) begin
				sum_view = {16'h0000, ~sum_view[15:0]};
			end
		end else begin
			if (cfg.sum_bit_rev) begin
				sum_view = ccu_bitrev32(sum_view);
			end
			if (cfg.sum_byte_rev) begin
				sum_view = ccu_byterev32(sum_view);
			end
			if (cfg.sum_cmpl) begin
				sum_view = ~sum_view;
			end
		end
		result_next = sum_view;
	end

	// ************************************************************
	// result register
	// ************************************************************
	// options are applied on every cycle, so a changed option shows one clock later
	// without a fresh data write; software should settle options before reading
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			result_reg <= 32'h00000000;
		end else begin
			result_reg <= result_next;
		end
	end

	// ************************************************************
	// sequencer registers
	// ************************************************************
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= CCU_ST_IDLE;
			crc_reg <= CCU_SEED_RST;
			buf_reg <= 32'h00000000;
			left_reg <= 2'h0;
			mode_reg <= CCU_MODE_CRC16;
			ready_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			crc_reg <= crc_next;
			buf_reg <= buf_next;
			left_reg <= left_next;
			mode_reg <= mode_next;
			ready_reg <= ready_next;
			busy_reg <= busy_next;
		end
	end

	// every output is a plain flop copy
	assign data_ready = ready_reg;
	assign busy = busy_reg;
	assign result = result_reg;
endmodule
`default_nettype wire

// [dv/ccu_asserts.sv]
// checker: timing and width properties of the checksum unit
`default_nettype none
module ccu_asserts (
	input wire logic clock, // bus clock
	input wire logic sys_rst, // async reset
	input wire ccu_pkg::ccu_cfg_s cfg, // options
	input wire logic [31:0] seed, // seed value
	input wire logic seed_wr, // seed strobe
	input wire logic [31:0] data, // data word
	input wire ccu_pkg::ccu_size_e data_size, // write size
	input wire logic data_wr, // data strobe
	input wire logic data_ready, // ready
	input wire logic busy, // stepping
	input wire logic [31:0] result // checksum
);
	import ccu_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// a seed write wins over a data write in the same cycle
	wire take = data_wr && data_ready && !seed_wr;
	a_busy_take: assert property (take |=> busy) else $error("no busy after write");
	a_byte_step: assert property (take && data_size == CCU_SIZE_BYTE |=> busy ##1 !busy) else $error("byte");
	a_half_steps: assert property (take && data_size == CCU_SIZE_HALF |=> busy[*2] ##1 !busy) else $error("half");
	a_word_steps: assert property (take && data_size == CCU_SIZE_WORD |=> busy[*4] ##1 !busy) else $error("word");
	a_ready_drop: assert property (data_wr && data_ready |=> !data_ready) else $error("ready held");
	a_busy_block: assert property (busy |-> !data_ready) else $error("ready while busy");
	a_seed_load: assert property (seed_wr && data_ready && cfg.mode == CCU_MODE_CRC32 && cfg[2:0] == 3'h0
		|=> result == $past(seed)) else $error("seed not loaded");
	a_width_16: assert property (!busy && cfg.mode != CCU_MODE_CRC32 |=> result[31:16] == 16'h0000)
		else $error("upper half set");
	a_result_hold: assert property (!busy && !$past(busy) && !data_wr && !seed_wr && $stable(cfg)
		|=> $stable(result)) else $error("result moved");
	cover property (take && cfg.dat_byte_rev && cfg.dat_bit_rev);
	cover property (take && data_size == CCU_SIZE_WORD);
	cover property (take && data_size == CCU_SIZE_HALF);
	cover property (seed_wr && data_ready);
endmodule
bind ccu_top ccu_asserts u_chk (.clock(clock), .sys_rst(sys_rst), .cfg(cfg), .seed(seed), .seed_wr(seed_wr),
	.data(data), .data_size(data_size), .data_wr(data_wr), .data_ready(data_ready), .busy(busy), .result(result));
`default_nettype wire

// [dv/ccu_dma_model.sv]
// writer model standing for the dma channel that feeds the data input
`default_nettype none
module ccu_dma_model (
	input wire logic clock, // bus clock
	input wire logic sys_rst, // async reset
	input wire logic req, // a write is pending
	input wire logic data_ready, // unit can take a write
	output logic data_wr // one-cycle write strobe
);
	// never strobes twice in a row: ready only falls a cycle after the take
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) data_wr <= 1'b0;
		else data_wr <= req && data_ready && !data_wr;
	end
endmodule
`default_nettype wire

// [dv/ccu_tb_top.sv]
// self-checking bench for the checksum unit with a reference model
`default_nettype none
module ccu_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ccu_pkg::*;
	logic clock = 1'b0, sys_rst = 1'b1, seed_wr = 1'b0, req = 1'b0, data_wr, data_ready, busy;
	logic [31:0] seed = '0, data = '0, result, rs = 32'h99C05C3D, exp, msk, poly, opt;
	ccu_cfg_s cfg = '0;
	ccu_size_e data_size = CCU_SIZE_BYTE;
	int fails = 0, n_tests = 0;
	ccu_top uut (.clock(clock), .sys_rst(sys_rst), .cfg(cfg), .seed(seed), .seed_wr(seed_wr), .data(data),
		.data_size(data_size), .data_wr(data_wr), .data_ready(data_ready), .busy(busy), .result(result));
	ccu_dma_model dma (.clock(clock), .sys_rst(sys_rst), .req(req), .data_ready(data_ready), .data_wr(data_wr));
	initial forever #2.5 clock = ~clock;
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	// mirror of the low w bits
	function automatic logic [31:0] mir(input logic [31:0] v, input int w);
		logic [31:0] r;
		r = 32'h00000000;
		for (int i = 0; i < w; i++) r[i] = v[w - 1 - i];
		return r;
	endfunction
	// output options in order: bit reverse, byte reverse, complement
	function automatic logic [31:0] want();
		logic [31:0] s;
		s = exp;
		if (cfg.sum_bit_rev) s = mir(s, msk[31] ? 32 : 16);
		if (cfg.sum_byte_rev) s = msk[31] ? {s[7:0], s[15:8], s[23:16], s[31:24]} : {16'h0000, s[7:0], s[15:8]};
		return cfg.sum_cmpl ? ~s & msk : s;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] ref_val);
		n_tests++;
		if (seen !== ref_val) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, ref_val);
		end
	endtask
	task automatic tally_and_finish();
		if (fails == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// msb-first fold, the top bit of the active width feeds back
	function automatic void fold(input logic [7:0] b);
		logic fb;
		for (int i = 7; i >= 0; i--) begin
			fb = (msk[31] ? exp[31] : exp[15]) ^ b[i];
			exp = ((exp << 1) ^ (fb ? poly : 32'h0)) & msk;
		end
	endfunction
	task automatic put(input logic [31:0] d, input int sz);
		int nb;
		logic [7:0] b;
		nb = 0;
		data <= d;
		data_size <= ccu_size_e'(sz);
		req <= 1'b1;
		d = cfg.dat_cmpl ? ~d : d;
		// msb byte first, or lsb byte first when the data bytes are reversed
		for (int k = 0; k < (1 << sz); k++) begin
			b = d[8 * (cfg.dat_byte_rev ? k : (1 << sz) - 1 - k) +: 8];
			fold(cfg.dat_bit_rev ? 8'(mir(32'(b), 8)) : b);
		end
		for (int i = 0; i < 9 && data_wr !== 1'b1; i++) @(posedge clock);
		req <= 1'b0;
		repeat (8) begin
			@(posedge clock);
			if (busy === 1'b1) nb++;
		end
		check(32'(nb), 32'(1 << sz));
		check(result, want());
		check(32'(data_ready), 32'h00000001);
	endtask
	// ****************
	// main sequence
	// ****************
	initial begin
		repeat (10) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		// first pass with every option off, second pass with random options
		for (int p = 0; p < 2; p++) for (int m = 0; m < 3; m++) begin
			poly = m == 0 ? 32'(CCU_POLY16) : m == 1 ? 32'(CCU_POLY_CCITT) : CCU_POLY32;
			msk = m == 2 ? 32'hFFFFFFFF : 32'h0000FFFF;
			opt = p == 0 ? 32'h00000000 : rnd();
			cfg <= '{mode: ccu_mode_e'(m), dat_cmpl: opt[0], dat_byte_rev: opt[1], dat_bit_rev: opt[2],
				sum_cmpl: opt[3], sum_byte_rev: opt[4], sum_bit_rev: opt[5]};
			seed <= rnd();
			seed_wr <= 1'b1;
			@(posedge clock);
			seed_wr <= 1'b0;
			exp = seed & msk;
			repeat (2) @(posedge clock);
			check(result, want());
			for (int k = 0; k < 12; k++) put(rnd(), k % 3);
		end
		tally_and_finish();
	end
	initial begin
		repeat (3000) @(posedge clock);
		fails++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
